// *** pkg/tps_consts.svh ***
// Register offsets, field positions and reset values of the sawtooth PWM block.
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH

`define TPS_ADDR_W          10
`define TPS_DATA_W          16

`define TPS_MODE_ADDR       10'h348
`define TPS_CTRL_ADDR       10'h349
`define TPS_BUF0_ADDR       10'h34a
`define TPS_BUF1_ADDR       10'h34b
`define TPS_DEAD_ADDR       10'h34c
`define TPS_CAR_ADDR        10'h380
`define TPS_UTMR_ADDR       10'h382
`define TPS_VTMR_ADDR       10'h384
`define TPS_WTMR_ADDR       10'h386
`define TPS_STAT_ADDR       10'h388

`define TPS_MODE_POL_BIT    0
`define TPS_MODE_INTSPEC_BIT 1
`define TPS_MODE_OUTCTL_BIT 3
`define TPS_MODE_PROT_BIT   4
`define TPS_MODE_SAW_BIT    6
`define TPS_CTRL_DUAL_BIT   1
`define TPS_CTRL_DTSRC_BIT  2

`define TPS_MODE_RST        8'h00
`define TPS_CTRL_RST        8'h00
`define TPS_BUF_RST         6'h00
`define TPS_DEAD_RST        8'hff
`define TPS_CAR_RST         16'hffff
`define TPS_TMR_RST         16'h0000
`define TPS_DT_DIV          8'h02

`endif

// *** pkg/tps_pkg.sv ***
// Types shared by the sawtooth PWM block.
package tps_pkg;

    typedef logic [15:0] tps_word_t;

    typedef struct packed {
        logic [7:0]        mode;
        logic [7:0]        ctrl;
        logic [5:0]        buf0;
        logic [5:0]        buf1;
        logic [7:0]        dead_rl;
        logic [15:0]       car_per;
        logic [2:0][15:0]  ph_val;
        logic [15:0]       car_cnt;
        logic [2:0][15:0]  ph_cnt;
        logic [2:0]        ph_run;
        logic [2:0][7:0]   dt_cnt;
        logic [7:0]        dt_div;
        logic [5:0][1:0]   sr;
        logic [5:0]        wave;
        logic              irq;
        logic [15:0]       rdata;
        logic              estop_q;
        logic [5:0]        pin;
        logic [5:0]        pin_oe;
    } tps_state_s;

endpackage

// *** hdl/tps_pwm.sv ***
// Three-phase complementary PWM generator in sawtooth modulation mode.
//
// Decided for this implementation: the register offsets and the plain strobed port.
`include "tps_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module tps_pwm
#(
    parameter logic [7:0] DT_DIV = `TPS_DT_DIV
)
(
    // Clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   sys_rst_in,
    // Register port
    input  wire logic [`TPS_ADDR_W-1:0] reg_addr_in,
    input  wire tps_pkg::tps_word_t     reg_wdata_in,
    input  wire logic                   reg_wr_in,
    input  wire logic                   reg_rd_in,
    output logic      [`TPS_DATA_W-1:0] reg_rdata_out,
    // Emergency stop
    input  wire logic                   estop_n_in,
    // Carrier interrupt request
    output logic                        carrier_irq_out,
    // Inverter gate pins
    output logic                        u_phase_pin_out,
    output logic                        u_comp_phase_pin_out,
    output logic                        v_phase_pin_out,
    output logic                        v_comp_phase_pin_out,
    output logic                        w_phase_pin_out,
    output logic                        w_comp_phase_pin_out,
    output logic      [5:0]             phase_pins_oe_out
);
    import tps_pkg::*;

    // Only sawtooth modulation lives here; the triangular mode and its second
    // timer registers are not built, so the dual-register bit merely stops the block.
    // The interrupt is a bare one-cycle request with no divider of its own, and
    // software must pick a carrier period longer than every phase timer plus dead time.

    tps_state_s st;
    tps_state_s next_st;
    logic       active;
    logic       carrier_zero;
    logic       dt_tick;
    logic       estop_fell;
    logic       prot_trip;
    logic [2:0] shift;
    logic [2:0] dt_busy;

    // The gating bit pair decides the mode; nothing else does.
    assign active       = st.mode[`TPS_MODE_SAW_BIT] && !st.ctrl[`TPS_CTRL_DUAL_BIT];
    assign carrier_zero = active && (st.car_cnt == 16'h0000);
    assign estop_fell   = st.estop_q && !estop_n_in;
    // Dead timers run either on every clock or on the divided enable.
    assign dt_tick      = !st.ctrl[`TPS_CTRL_DTSRC_BIT] || (st.dt_div == 8'h00);

    for (genvar gp = 0; gp < 3; gp++)
    begin : g_phase
        assign shift[gp]   = st.ph_run[gp] && (st.ph_cnt[gp] == 16'h0000);
        assign dt_busy[gp] = (st.dt_cnt[gp] != 8'h00);
    end

    assign prot_trip = st.mode[`TPS_MODE_PROT_BIT] && (
        (!st.wave[0] && !st.wave[1]) ||
        (!st.wave[2] && !st.wave[3]) ||
        (!st.wave[4] && !st.wave[5]));

    always_comb
    begin
        next_st = st;
        next_st.irq = carrier_zero;
        next_st.rdata = 16'h0000;
        next_st.estop_q = estop_n_in;

        // Writes land in the state one cycle later and an unmapped address is
        // dropped. Nothing on this port ever waits, so a read and a write may
        // follow each other on consecutive cycles.
        // The interrupt spec and polarity bits are stored but never read here.
        if (reg_wr_in)
        begin
            case (reg_addr_in)
                `TPS_MODE_ADDR: next_st.mode = reg_wdata_in[7:0];
                `TPS_CTRL_ADDR: next_st.ctrl = reg_wdata_in[7:0];
                `TPS_BUF0_ADDR: next_st.buf0 = reg_wdata_in[5:0];
                `TPS_BUF1_ADDR: next_st.buf1 = reg_wdata_in[5:0];
                `TPS_DEAD_ADDR: next_st.dead_rl = reg_wdata_in[7:0];
                `TPS_CAR_ADDR:  next_st.car_per = reg_wdata_in;
                `TPS_UTMR_ADDR: next_st.ph_val[0] = reg_wdata_in;
                `TPS_VTMR_ADDR: next_st.ph_val[1] = reg_wdata_in;
                `TPS_WTMR_ADDR: next_st.ph_val[2] = reg_wdata_in;
                default:        next_st.mode = st.mode;
            endcase
        end

        // Read data stand for one cycle only and fall back to zero, so a late
        // sampler sees zero rather than a stale word.
        if (reg_rd_in)
        begin
            case (reg_addr_in)
                `TPS_MODE_ADDR: next_st.rdata = {8'h00, st.mode};
                `TPS_CTRL_ADDR: next_st.rdata = {8'h00, st.ctrl};
                `TPS_BUF0_ADDR: next_st.rdata = {10'h000, st.buf0};
                `TPS_BUF1_ADDR: next_st.rdata = {10'h000, st.buf1};
                `TPS_DEAD_ADDR: next_st.rdata = {8'h00, st.dead_rl};
                `TPS_CAR_ADDR:  next_st.rdata = st.car_per;
                `TPS_UTMR_ADDR: next_st.rdata = st.ph_val[0];
                `TPS_VTMR_ADDR: next_st.rdata = st.ph_val[1];
                `TPS_WTMR_ADDR: next_st.rdata = st.ph_val[2];
                `TPS_STAT_ADDR: next_st.rdata = {3'h0, active, dt_busy, st.ph_run, st.wave};
                default:        next_st.rdata = 16'h0000;
            endcase
        end

        // Carrier counts down and reloads its period on reaching zero.
        if (!active || carrier_zero)
        begin
            next_st.car_cnt = st.car_per;
        end
        else
        begin
            next_st.car_cnt = st.car_cnt - 16'h0001;
        end

        // The divider free-runs; a dead time on the slow source may therefore
        // be up to one divided period shorter than its reload suggests.
        if (!st.ctrl[`TPS_CTRL_DTSRC_BIT] || st.dt_div == 8'h00)
        begin
            next_st.dt_div = DT_DIV - 8'h01;
        end
        else
        begin
            next_st.dt_div = st.dt_div - 8'h01;
        end

        // Each pair owns its one-shot and its dead timer; the two outputs of a
        // pair share both, which keeps their edges aligned.
        for (int p = 0; p < 3; p++)
        begin
            // A carrier zero always restarts the one-shot, even mid-count.
            if (carrier_zero)
            begin
                next_st.ph_cnt[p] = st.ph_val[p];
                next_st.ph_run[p] = 1'b1;
            end
            else if (shift[p])
            begin
                next_st.ph_run[p] = 1'b0;
            end
            else if (st.ph_run[p])
            begin
                next_st.ph_cnt[p] = st.ph_cnt[p] - 16'h0001;
            end

            // A retrigger reloads the shared value and restarts the count.
            if (shift[p])
            begin
                next_st.dt_cnt[p] = st.dead_rl;
            end
            else if (dt_busy[p] && dt_tick)
            begin
                next_st.dt_cnt[p] = st.dt_cnt[p] - 8'h01;
            end

            for (int c = 0; c < 2; c++)
            begin
                if (carrier_zero)
                begin
                    next_st.sr[2*p+c] = {st.buf1[2*p+c], st.buf0[2*p+c]};
                    next_st.wave[2*p+c] = st.buf0[2*p+c];
                end
                else if (shift[p])
                begin
                    next_st.sr[2*p+c] = {st.sr[2*p+c][1], st.sr[2*p+c][1]};
                    // A rise takes effect at once; a fall waits for the dead time.
                    next_st.wave[2*p+c] = st.sr[2*p+c][1] ||
                        (st.wave[2*p+c] && st.dead_rl != 8'h00);
                end
                else
                begin
                    next_st.wave[2*p+c] = st.sr[2*p+c][0] ||
                        (st.wave[2*p+c] && dt_busy[p]);
                end
            end
        end

        // Stop and protection win over a write in the same cycle.
        if (estop_fell || prot_trip)
        begin
            next_st.mode[`TPS_MODE_OUTCTL_BIT] = 1'b0;
        end

        // Pins follow the next waveform so that they leave a flip-flop in the
        // same cycle as the state that produced them.
        next_st.pin = next_st.wave;
        next_st.pin_oe = {6{next_st.mode[`TPS_MODE_OUTCTL_BIT]}};

        // Reset is last so that it overrides every update above, including a
        // write or a carrier zero that falls in the same cycle.
        if (sys_rst_in)
        begin
            next_st = '0;
            next_st.mode = `TPS_MODE_RST;
            next_st.ctrl = `TPS_CTRL_RST;
            next_st.buf0 = `TPS_BUF_RST;
            next_st.buf1 = `TPS_BUF_RST;
            next_st.dead_rl = `TPS_DEAD_RST;
            next_st.car_per = `TPS_CAR_RST;
            next_st.car_cnt = `TPS_CAR_RST;
            next_st.ph_val = {3{`TPS_TMR_RST}};
            next_st.estop_q = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        st <= next_st;
    end

    assign reg_rdata_out        = st.rdata;
    assign carrier_irq_out      = st.irq;
    assign u_phase_pin_out      = st.pin[0];
    assign u_comp_phase_pin_out = st.pin[1];
    assign v_phase_pin_out      = st.pin[2];
    assign v_comp_phase_pin_out = st.pin[3];
    assign w_phase_pin_out      = st.pin[4];
    assign w_comp_phase_pin_out = st.pin[5];
    assign phase_pins_oe_out    = st.pin_oe;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (sys_rst_in);

    irq_on_zero_a: assert property (carrier_zero |=> carrier_irq_out)
        else $error("carrier zero did not raise the interrupt");
    mode_gate_a: assert property (!active |=> !carrier_irq_out)
        else $error("interrupt raised outside sawtooth mode");
    timer_reload_a: assert property (
        carrier_zero |=> st.ph_run[0] && st.ph_cnt[0] == $past(st.ph_val[0]))
        else $error("phase timer not reloaded at carrier zero");
    load_first_a: assert property (
        carrier_zero |=> st.wave[1] == $past(st.buf0[1]) && st.sr[0] == $past({st.buf1[0], st.buf0[0]}))
        else $error("buffer bits not loaded at carrier zero");
    shift_hold_a: assert property (
        shift[0] && !carrier_zero |=> st.sr[0][0] == $past(st.sr[0][1]) && !st.ph_run[0])
        else $error("shift register did not advance");
    dead_trigger_a: assert property (shift[1] |=> st.dt_cnt[1] == $past(st.dead_rl))
        else $error("dead timer not triggered on shift");
    fall_wait_a: assert property (
        st.wave[0] && dt_busy[0] && !carrier_zero && !shift[0] |=> st.wave[0])
        else $error("output fell during dead time");
    comp_high_a: assert property (
        st.sr[1] == 2'b11 && !carrier_zero ##1 !carrier_zero |=> st.wave[1])
        else $error("complement output left high state");
    estop_clear_a: assert property ($fell(estop_n_in) |=> phase_pins_oe_out == 6'h00)
        else $error("emergency stop did not release pins");
    prot_release_a: assert property (prot_trip |=> !st.mode[`TPS_MODE_OUTCTL_BIT])
        else $error("simultaneous low did not release pins");

    // Every pair reloads from the buffer, not only the U pair.
    comp_load_a: assert property (
        carrier_zero |=> st.sr[1] == $past({st.buf1[1], st.buf0[1]}))
        else $error("complement shift register not loaded");
    reload_all_a: assert property (
        carrier_zero |=> st.sr[5] == $past({st.buf1[5], st.buf0[5]})
            && st.wave[4] == $past(st.buf0[4]))
        else $error("W pair not reloaded at carrier zero");
    vw_reload_a: assert property (
        carrier_zero |=> st.ph_cnt[1] == $past(st.ph_val[1])
            && st.ph_cnt[2] == $past(st.ph_val[2]))
        else $error("V or W timer not reloaded");
    load_v_a: assert property (carrier_zero |=> st.wave[2] == $past(st.buf0[2]))
        else $error("V first bit not applied");

    // Shift side of every pair.
    comp_wave_a: assert property (
        shift[0] && !carrier_zero && st.sr[1][1] |=> st.wave[1])
        else $error("complement output missed its high bit");
    shift_v_a: assert property (
        shift[1] && !carrier_zero |=> !st.ph_run[1] && st.sr[2][0] == $past(st.sr[2][1]))
        else $error("V shift register did not advance");
    rise_now_a: assert property (
        shift[2] && !carrier_zero && st.sr[4][1] |=> st.wave[4])
        else $error("rising bit delayed");
    fall_end_a: assert property (
        st.wave[0] && !st.sr[0][0] && !dt_busy[0] && !carrier_zero && !shift[0] |=> !st.wave[0])
        else $error("output held after dead time");
    final_hold_a: assert property (
        !st.ph_run[0] && !carrier_zero |=> $stable(st.sr[0]))
        else $error("shift register moved without a shift");

    // Dead timers.
    dead_count_a: assert property (
        dt_busy[0] && dt_tick && !shift[0] |=> st.dt_cnt[0] == $past(st.dt_cnt[0]) - 8'h01)
        else $error("dead timer did not count down");
    dead_idle_a: assert property (!dt_busy[2] && !shift[2] |=> !dt_busy[2])
        else $error("dead timer started without a trigger");
    div_tick_a: assert property (
        st.ctrl[`TPS_CTRL_DTSRC_BIT] && st.dt_div != 8'h00 |=> st.dt_div == $past(st.dt_div) - 8'h01)
        else $error("dead time divider did not count");
    dead_w_a: assert property (shift[2] |=> st.dt_cnt[2] == $past(st.dead_rl))
        else $error("W dead timer not triggered");

    // Output control, interrupt and idle carrier.
    pin_enable_a: assert property (phase_pins_oe_out == {6{st.mode[`TPS_MODE_OUTCTL_BIT]}})
        else $error("pin enables differ from output control");
    estop_wins_a: assert property (estop_fell |=> !st.mode[`TPS_MODE_OUTCTL_BIT])
        else $error("emergency stop did not clear output control");
    irq_only_zero_a: assert property (carrier_irq_out |-> $past(carrier_zero))
        else $error("interrupt without carrier zero");
    idle_reload_a: assert property (
        !active |=> st.car_cnt == $past(st.car_per))
        else $error("carrier counted outside sawtooth mode");

    zero_event_c: cover property (carrier_zero ##[1:20] shift[0]);
    dead_hold_c: cover property (shift[0] && st.wave[0] && !st.sr[0][1]);
    estop_c: cover property (st.pin_oe[0] ##1 $fell(estop_n_in));
    comp_only_c: cover property (carrier_zero && st.buf0[1] && st.buf1[1]);
    prot_trip_c: cover property (prot_trip && phase_pins_oe_out[0]);

endmodule

`default_nettype wire

// *** verification/tps_gate_model.sv ***
// Behavioural inverter gate drive stage facing the sawtooth PWM pins.
`timescale 1ns/1ns
`default_nettype none
module tps_gate_model
(
    // Clock
    input  wire logic       core_clk_in,
    // Gate pins and their enables
    input  wire logic [5:0] pins_in,
    input  wire logic [5:0] oe_in,
    // A pair is driven low on both sides
    output logic            shoot_out
);
    logic [5:0] gate;
    // A released pin is pulled up, so its switch stays off.
    assign gate = (pins_in & oe_in) | ~oe_in;
    always_ff @(posedge core_clk_in)
    begin
        shoot_out <= ~(gate[0] | gate[1]) | ~(gate[2] | gate[3]) | ~(gate[4] | gate[5]);
    end
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// Self-checking bench for the sawtooth PWM block.
`include "tps_consts.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
    import tps_pkg::*;
    logic        clk;
    logic        rst;
    logic        wr;
    logic        rd;
    logic        estop_n;
    logic [9:0]  addr;
    tps_word_t   wdata;
    logic [15:0] rdata;
    logic        irq;
    logic [5:0]  pins;
    logic [5:0]  oe;
    logic        shoot;
    logic        ok;
    logic [5:0]  b0;
    logic [5:0]  b1;
    logic [7:0]  mb;
    int          t[3];
    int          d;
    int          p;
    int          n_errors;
    int          check_count;

    tps_pwm tps_pwm_inst (.core_clk_in(clk), .sys_rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .estop_n_in(estop_n), .carrier_irq_out(irq), .u_phase_pin_out(pins[0]),
        .u_comp_phase_pin_out(pins[1]), .v_phase_pin_out(pins[2]),
        .v_comp_phase_pin_out(pins[3]), .w_phase_pin_out(pins[4]),
        .w_comp_phase_pin_out(pins[5]), .phase_pins_oe_out(oe));
    tps_gate_model tps_gate_model_inst (.core_clk_in(clk), .pins_in(pins), .oe_in(oe),
        .shoot_out(shoot));

    // Pin levels k cycles after the carrier interrupt cycle.
    function automatic logic [5:0] exp_pins(int k);
        logic [5:0] e;
        for (int j = 0; j < 6; j++)
        begin
            if (k < t[j / 2] + 1) e[j] = b0[j];
            else if (b0[j] && !b1[j] && k < t[j / 2] + d + 2) e[j] = 1'b1;
            else e[j] = b1[j];
        end
        return e;
    endfunction

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [9:0] a, input logic [15:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [9:0] a, input logic [15:0] exp, input string msg);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, msg);
    endtask

    task automatic wait_irq();
        ok = 1'b0;
        for (int i = 0; i < 2000 && !ok; i++)
        begin
            @(posedge clk);
            #1;
            ok = (irq === 1'b1);
        end
        if (!ok)
        begin
            n_errors++;
            $display("ERROR %0t no carrier interrupt", $time);
            stop_test();
        end
    endtask

    // Stopping first keeps the shift registers from reloading while the setup is rewritten.
    task automatic run_cfg();
        wr_reg(`TPS_MODE_ADDR, 16'h0000);
        wr_reg(`TPS_BUF0_ADDR, 16'(b0));
        wr_reg(`TPS_BUF1_ADDR, 16'(b1));
        wr_reg(`TPS_DEAD_ADDR, 16'(d));
        wr_reg(`TPS_CAR_ADDR, 16'(p));
        wr_reg(`TPS_UTMR_ADDR, 16'(t[0]));
        wr_reg(`TPS_VTMR_ADDR, 16'(t[1]));
        wr_reg(`TPS_WTMR_ADDR, 16'(t[2]));
        wr_reg(`TPS_CTRL_ADDR, 16'h0000);
        wr_reg(`TPS_MODE_ADDR, {8'h00, 8'h48 | mb});
        wait_irq();
        for (int k = 0; k < 2 * p + 2; k++)
        begin
            chk(16'(irq), 16'(k == 0 || k == p + 1), "carrier irq");
            chk(16'(pins), 16'(exp_pins(k % (p + 1))), "phase pins");
            chk(16'(oe), 16'h003f, "pin enable");
            @(posedge clk);
            #1;
        end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        estop_n = 1'b1;
        addr = 10'h000;
        wdata = 16'h0000;
        n_errors = 0;
        check_count = 0;
        void'($urandom(32'h2803));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd_reg(`TPS_MODE_ADDR, 16'h0000, "mode reset");
        rd_reg(`TPS_DEAD_ADDR, 16'h00ff, "dead reset");
        rd_reg(`TPS_CAR_ADDR, 16'hffff, "carrier reset");
        rd_reg(10'h3ff, 16'h0000, "unmapped read");
        wr_reg(`TPS_CAR_ADDR, 16'h0009);
        wr_reg(`TPS_CTRL_ADDR, 16'h0002);
        wr_reg(`TPS_MODE_ADDR, 16'h0048);
        for (int k = 0; k < 40; k++)
        begin
            @(posedge clk);
            #1;
            chk(16'(irq), 16'h0000, "dual register irq");
        end
        for (int r = 0; r < 8; r++)
        begin
            if (r == 0)
            begin
                b0 = 6'h01;
                b1 = 6'h02;
                t = '{3, 3, 3};
                d = 2;
                p = 9;
                mb = 8'h00;
            end
            else if (r == 1)
            begin
                // Complement bits held at one in every pair.
                b0 = 6'h2b;
                b1 = 6'h2e;
                t = '{2, 5, 1};
                d = 1;
                p = 12;
                mb = 8'h03;
            end
            else
            begin
                b0 = 6'($urandom);
                b1 = 6'($urandom);
                foreach (t[i]) t[i] = 1 + $urandom % 8;
                d = 1 + $urandom % 6;
                p = 20 + $urandom % 10;
                mb = 8'($urandom % 4);
            end
            run_cfg();
        end
        @(posedge clk);
        estop_n <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(16'(oe), 16'h0000, "estop release");
        rd_reg(`TPS_MODE_ADDR, {8'h00, 8'h40 | mb}, "estop mode");
        estop_n <= 1'b1;
        wr_reg(`TPS_MODE_ADDR, 16'h0000);
        wr_reg(`TPS_BUF0_ADDR, 16'h0000);
        wr_reg(`TPS_BUF1_ADDR, 16'h0000);
        // Divided dead-time source, so the slow count path runs at least once.
        wr_reg(`TPS_CTRL_ADDR, 16'h0004);
        wr_reg(`TPS_MODE_ADDR, 16'h0058);
        wait_irq();
        repeat (3) @(posedge clk);
        #1;
        chk(16'(oe), 16'h0000, "protect release");
        chk(16'(shoot), 16'h0000, "gate both low");
        rd_reg(`TPS_MODE_ADDR, 16'h0050, "protect mode");
        stop_test();
    end
endmodule
`default_nettype wire
